// ---- src/pdt_pkg.sv ----
// Purpose: Shared constants and types for the dual pulse edge timing block.
// Assumes: One 25 MHz core clock; byte-wide register access port.
// Notes: Edge times are counted in fine 5 ns units inside the block.
package pdt_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] PDT_OUT1_RISE_TIME_HIGH = 16'hfe0c;
  localparam logic [15:0] PDT_OUT1_RISE_SETTING = 16'hfe0d;
  localparam logic [15:0] PDT_OUT1_FALL_TIME_HIGH = 16'hfe0e;
  localparam logic [15:0] PDT_OUT1_FALL_SETTING = 16'hfe0f;
  localparam logic [15:0] PDT_OUT2_RISE_TIME_HIGH = 16'hfe10;
  localparam logic [15:0] PDT_OUT2_RISE_SETTING = 16'hfe11;
  localparam logic [15:0] PDT_OUT2_FALL_TIME_HIGH = 16'hfe12;
  localparam logic [15:0] PDT_OUT2_FALL_SETTING = 16'hfe13;
  localparam logic [15:0] PDT_PULSE_CONTROL = 16'hfe14;
  localparam int PDT_NUM_EDGES = 4;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PDT_SET_LOW_MSB = 3;
  localparam int PDT_SET_LOW_LSB = 2;
  localparam int PDT_SET_MOD_EN = 1;
  localparam int PDT_SET_SIGN = 0;
  localparam int PDT_CTL_MODE = 4;
  localparam int PDT_CTL_RES = 3;
  localparam int PDT_CTL_DIS1 = 2;
  localparam int PDT_CTL_DIS2 = 1;
  localparam int PDT_CTL_GO = 0;
  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0] PDT_RESET_BYTE = 8'h00;
  localparam int PDT_CLK_PERIOD_NS = 40;
  localparam int PDT_FINE_STEP_NS = 5;
  localparam int PDT_COARSE_STEP_NS = 40;
  localparam int PDT_CNT_STEP = PDT_CLK_PERIOD_NS / PDT_FINE_STEP_NS;
  localparam int PDT_COARSE_SHIFT = $clog2(PDT_COARSE_STEP_NS / PDT_FINE_STEP_NS);
  localparam logic [9:0] PDT_TIME_MAX = 10'h3ff;
  localparam int PDT_CNT_W = 14;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] time_high;
    logic [1:0] time_low;
    logic mod_en;
    logic sign;
  } pdt_edge_t;
  typedef struct packed {
    logic bridgeless;
    logic fine_res;
    logic dis1;
    logic dis2;
    logic go;
  } pdt_ctrl_t;
endpackage

// ---- src/pdt_dual_edge.sv ----
// Purpose: Places the rising and falling edges of two gate-drive pulse outputs.
// Assumes: Register port and modulation input are synchronous to clock.
// Notes: Edges land on the 40 ns core clock grid; 5 ns codes are rounded up.
`timescale 1ns/1ps
`default_nettype none
module pdt_dual_edge (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  input wire logic [pdt_pkg::PDT_CNT_W-1:0] period_len,
  input wire logic [9:0] mod_value,
  output logic gate_output,
  output logic second_gate_output,
  output logic bridgeless_mode,
  output logic period_start
);
  import pdt_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Returns edge index 0..3 for timing/setting registers, 4 for control, 7 unmapped.
  function automatic logic [2:0] reg_index(input logic [15:0] a);
    logic [2:0] idx;
    idx = 3'h7;
    if (a >= PDT_OUT1_RISE_TIME_HIGH && a <= PDT_OUT2_FALL_SETTING) begin
      idx = 3'(((a - PDT_OUT1_RISE_TIME_HIGH) >> 1));
    end else if (a == PDT_PULSE_CONTROL) begin
      idx = 3'h4;
    end
    return idx;
  endfunction

  // Modulated edge time, clamped so an edge never leaves the 10-bit range.
  function automatic logic [9:0] edge_time(input pdt_edge_t e, input logic [9:0] m);
    logic [10:0] sum;
    logic [9:0] base;
    sum = 11'h000;
    base = {e.time_high, e.time_low};
    edge_time = base;
    if (e.mod_en) begin
      if (e.sign) begin
        sum = {1'b0, base} + {1'b0, m};
        edge_time = sum[10] ? PDT_TIME_MAX : sum[9:0];
      end else begin
        edge_time = (base < m) ? 10'h000 : base - m;
      end
    end
  endfunction

  // Packs one edge's setting byte; reserved bits 7:4 always read zero.
  function automatic logic [7:0] setting_byte(input pdt_edge_t e);
    setting_byte = PDT_RESET_BYTE;
    setting_byte[PDT_SET_LOW_MSB:PDT_SET_LOW_LSB] = e.time_low;
    setting_byte[PDT_SET_MOD_EN] = e.mod_en;
    setting_byte[PDT_SET_SIGN] = e.sign;
  endfunction

  // Scales an edge time into 5 ns counter units for the selected step.
  function automatic logic [PDT_CNT_W-1:0] edge_pos(input logic [9:0] t, input logic fine);
    logic [PDT_CNT_W-1:0] wide;
    wide = PDT_CNT_W'(t);
    edge_pos = fine ? wide : wide << PDT_COARSE_SHIFT;
  endfunction

  // True while the count sits inside the high window of one output.
  function automatic logic in_window(input logic [PDT_CNT_W-1:0] c,
                                     input logic [PDT_CNT_W-1:0] rise,
                                     input logic [PDT_CNT_W-1:0] fall);
    // A rise after the fall wraps the pulse over the period boundary.
    if (rise <= fall) begin
      in_window = (c >= rise) && (c < fall);
    end else begin
      in_window = (c >= rise) || (c < fall);
    end
  endfunction

  // ****************************************************************
  // Shadow and active registers
  // ****************************************************************
  pdt_edge_t shadow_r [PDT_NUM_EDGES];
  pdt_edge_t active_r [PDT_NUM_EDGES];
  pdt_ctrl_t ctrl_r;
  pdt_ctrl_t ctrl_act_r;
  logic go_prev_r;
  logic commit;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;

  assign wr_idx = reg_index(reg_addr);
  assign rd_idx = wr_idx;
  assign commit = ctrl_r.go & ~go_prev_r;

  genvar g;
  generate
    for (g = 0; g < PDT_NUM_EDGES; g++) begin : g_edge
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          shadow_r[g] <= '0;
        end else if (reg_wr_en && wr_idx == 3'(g)) begin
          if (!reg_addr[0]) begin
            shadow_r[g].time_high <= reg_wdata;
          end else begin
            shadow_r[g].time_low <= reg_wdata[PDT_SET_LOW_MSB:PDT_SET_LOW_LSB];
            shadow_r[g].mod_en <= reg_wdata[PDT_SET_MOD_EN];
            shadow_r[g].sign <= reg_wdata[PDT_SET_SIGN];
          end
        end
      end

      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          active_r[g] <= '0;
        end else if (commit) begin
          active_r[g] <= shadow_r[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= '0;
    end else if (reg_wr_en && wr_idx == 3'h4) begin
      ctrl_r.bridgeless <= reg_wdata[PDT_CTL_MODE];
      ctrl_r.fine_res <= reg_wdata[PDT_CTL_RES];
      ctrl_r.dis1 <= reg_wdata[PDT_CTL_DIS1];
      ctrl_r.dis2 <= reg_wdata[PDT_CTL_DIS2];
      ctrl_r.go <= reg_wdata[PDT_CTL_GO];
    end
  end

  // ****************************************************************
  // Commit tracking
  // ****************************************************************
  // Only the go rise copies settings, so half-written edges never reach the gates.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      go_prev_r <= 1'b0;
    end else begin
      go_prev_r <= ctrl_r.go;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_act_r <= '0;
    end else if (commit) begin
      ctrl_act_r <= ctrl_r;
    end
  end

  // ****************************************************************
  // Register read-back
  // ****************************************************************
  logic [7:0] rd_nxt;

  always_comb begin
    rd_nxt = PDT_RESET_BYTE;
    if (rd_idx < 3'h4) begin
      if (!reg_addr[0]) begin
        rd_nxt = shadow_r[rd_idx[1:0]].time_high;
      end else begin
        rd_nxt = setting_byte(shadow_r[rd_idx[1:0]]);
      end
    end else if (rd_idx == 3'h4) begin
      rd_nxt = {3'h0, ctrl_r.bridgeless, ctrl_r.fine_res,
                ctrl_r.dis1, ctrl_r.dis2, ctrl_r.go};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= PDT_RESET_BYTE;
    end else if (reg_rd_en) begin
      reg_rdata <= rd_nxt;
    end
  end

  // ****************************************************************
  // Switching period counter
  // ****************************************************************
  // The count runs in 5 ns units and advances a whole core clock each cycle.
  logic [PDT_CNT_W-1:0] cnt_r;
  logic [PDT_CNT_W:0] cnt_sum;
  logic [9:0] mod_r;
  logic wrap;

  assign cnt_sum = {1'b0, cnt_r} + (PDT_CNT_W+1)'(PDT_CNT_STEP);
  assign wrap = cnt_sum >= {1'b0, period_len};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (wrap) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_sum[PDT_CNT_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      period_start <= 1'b0;
    end else begin
      period_start <= wrap;
    end
  end

  // Sampling once per period keeps both edges of a non-wrapping pulse on one modulation value.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mod_r <= 10'h000;
    end else if (wrap) begin
      mod_r <= mod_value;
    end
  end

  // ****************************************************************
  // Edge compare and outputs
  // ****************************************************************
  logic [PDT_CNT_W-1:0] pos [PDT_NUM_EDGES];
  logic [1:0] win;

  generate
    for (g = 0; g < PDT_NUM_EDGES; g++) begin : g_pos
      logic [9:0] t;
      assign t = edge_time(active_r[g], mod_r);
      assign pos[g] = edge_pos(t, ctrl_act_r.fine_res);
    end
    for (g = 0; g < 2; g++) begin : g_win
      assign win[g] = in_window(cnt_r, pos[2*g], pos[2*g+1]);
    end
  endgenerate

  // ****************************************************************
  // Output stage
  // ****************************************************************
  // Fine codes between clock ticks land on the next 40 ns tick; that is a limitation.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gate_output <= 1'b0;
    end else begin
      gate_output <= win[0] & ~ctrl_act_r.dis1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      second_gate_output <= 1'b0;
    end else begin
      second_gate_output <= win[1] & ~ctrl_act_r.dis2;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bridgeless_mode <= 1'b0;
    end else begin
      bridgeless_mode <= ctrl_act_r.bridgeless;
    end
  end
endmodule // pdt_dual_edge
`default_nettype wire

// ---- verif/pdt_gate_drv_model.sv ----
// Purpose: Gate driver stand-in that counts on-cycles per switching period.
// Assumes: Both gates are sampled on the core clock.
// Notes: Counts latch at each period start, so any window spans one whole period.
`timescale 1ns/1ps
`default_nettype none
module pdt_gate_drv_model (
  input wire logic clock,
  input wire logic period_start,
  input wire logic gate_output,
  input wire logic second_gate_output,
  output logic [7:0] hi1,
  output logic [7:0] hi2
);
  logic [7:0] acc1 = 8'h00;
  logic [7:0] acc2 = 8'h00;
  always @(posedge clock) begin
    if (period_start) begin
      hi1 <= acc1;
      hi2 <= acc2;
      acc1 <= {7'h00, gate_output};
      acc2 <= {7'h00, second_gate_output};
    end else begin
      acc1 <= acc1 + {7'h00, gate_output};
      acc2 <= acc2 + {7'h00, second_gate_output};
    end
  end
endmodule // pdt_gate_drv_model
`default_nettype wire

// ---- verif/pdt_dual_edge_sva.sv ----
// Purpose: Port checker for the dual pulse edge block.
// Assumes: One clock; rstn is asynchronous and active low.
// Notes: Committed control bits are rebuilt from writes, since they are not ports.
`timescale 1ns/1ps
`default_nettype none
module pdt_dual_edge_sva import pdt_pkg::*; (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic [pdt_pkg::PDT_CNT_W-1:0] period_len,
  input wire logic gate_output,
  input wire logic second_gate_output,
  input wire logic bridgeless_mode,
  input wire logic period_start
);
  logic [4:0] sh_r;
  logic [4:0] act_r;
  logic go_q_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sh_r <= 5'h00;
      act_r <= 5'h00;
      go_q_r <= 1'b0;
    end else begin
      if (reg_wr_en && reg_addr == PDT_PULSE_CONTROL) begin
        sh_r <= reg_wdata[4:0];
      end
      go_q_r <= sh_r[0];
      if (sh_r[0] && !go_q_r) begin
        act_r <= sh_r;
      end
    end
  end
  sequence s_no_read;
    !reg_rd_en [*2];
  endsequence
  property p_hold; s_no_read |=> $stable(reg_rdata); endproperty
  property p_unmap; reg_rd_en && (reg_addr < PDT_OUT1_RISE_TIME_HIGH ||
    reg_addr > PDT_PULSE_CONTROL) |=> reg_rdata == 8'h00; endproperty
  property p_rsv_set; reg_rd_en && reg_addr[0] && reg_addr > PDT_OUT1_RISE_TIME_HIGH &&
    reg_addr < PDT_PULSE_CONTROL |=> reg_rdata[7:4] == 4'h0; endproperty
  property p_rsv_ctl; reg_rd_en && reg_addr == PDT_PULSE_CONTROL |=> reg_rdata[7:5] == 3'h0;
  endproperty
  property p_dis1; act_r[2] |=> !gate_output; endproperty
  property p_dis2; act_r[1] |=> !second_gate_output; endproperty
  property p_mode; $stable(act_r[4]) [*3] |-> bridgeless_mode == act_r[4]; endproperty
  property p_period; period_start && period_len == 14'h0050 |=>
    !period_start [*8] ##1 !period_start ##1 period_start; endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_rsv_set: assert property (p_rsv_set) else $error("setting bits 7:4 not zero");
  a_rsv_ctl: assert property (p_rsv_ctl) else $error("control bits 7:5 not zero");
  a_dis1: assert property (p_dis1) else $error("first output high while disabled");
  a_dis2: assert property (p_dis2) else $error("second output high while disabled");
  a_mode: assert property (p_mode) else $error("mode differs from commit");
  a_period: assert property (p_period) else $error("period start spacing wrong");
endmodule // pdt_dual_edge_sva
bind pdt_dual_edge pdt_dual_edge_sva u_pdt_dual_edge_sva (.clock(clock), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
  .reg_rdata(reg_rdata), .period_len(period_len), .gate_output(gate_output),
  .second_gate_output(second_gate_output), .bridgeless_mode(bridgeless_mode),
  .period_start(period_start));
`default_nettype wire

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the dual pulse edge block.
// Assumes: 25 MHz clock; inputs change on the falling edge.
// Notes: A period of 80 fine units is ten clocks, so on-times are small whole counts.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pdt_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_rdata;
  logic [13:0] period_len = 14'h0050;
  logic [9:0] mod_value = 10'h000;
  logic gate_output, second_gate_output, bridgeless_mode, period_start;
  logic [7:0] hi1, hi2;
  int error_cnt = 0;
  int total_checks = 0;
  always #20 clock = ~clock;
  pdt_dual_edge u_pdt_dual_edge (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .period_len(period_len), .mod_value(mod_value),
    .gate_output(gate_output), .second_gate_output(second_gate_output),
    .bridgeless_mode(bridgeless_mode), .period_start(period_start));
  pdt_gate_drv_model u_pdt_gate_drv_model (.clock(clock), .period_start(period_start),
    .gate_output(gate_output), .second_gate_output(second_gate_output), .hi1(hi1), .hi2(hi2));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clock);
    reg_wr_en = 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clock);
    reg_rd_en = 1'b0;
    @(negedge clock);
    check(reg_rdata, e);
  endtask
  // Go is dropped first, because only its rise commits the settings.
  task automatic cm(input logic [7:0] d);
    wr(PDT_PULSE_CONTROL, d);
    wr(PDT_PULSE_CONTROL, d | 8'h01);
  endtask
  task automatic meas(input logic [7:0] e1, input logic [7:0] e2);
    int n;
    repeat (4) begin
      n = 0;
      do begin
        @(negedge clock);
        n++;
      end while (!period_start && n < 40);
    end
    @(negedge clock);
    check(hi1, e1);
    check(hi2, e2);
  endtask
  task automatic stop_test();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    for (int i = 0; i < 9; i++) rdc(PDT_OUT1_RISE_TIME_HIGH + 16'(i), 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(PDT_OUT1_RISE_TIME_HIGH + 16'(i), 8'hff);
      rdc(PDT_OUT1_RISE_TIME_HIGH + 16'(i), i == 8 ? 8'h1f : i[0] ? 8'h0f : 8'hff);
    end
    wr(16'hfe15, 8'hff);
    rdc(16'hfe15, 8'h00);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    wr(16'hfe0d, 8'h08);
    wr(16'hfe0e, 8'h01);
    wr(16'hfe0f, 8'h04);
    wr(16'hfe10, 8'h01);
    wr(16'hfe12, 8'h02);
    wr(16'hfe13, 8'h04);
    meas(8'h00, 8'h00);
    cm(8'h00);
    meas(8'h03, 8'h05);
    wr(PDT_PULSE_CONTROL, 8'h05);
    meas(8'h03, 8'h05);
    cm(8'h04);
    meas(8'h00, 8'h05);
    cm(8'h02);
    meas(8'h03, 8'h00);
    cm(8'h10);
    repeat (2) @(negedge clock);
    check({7'h00, bridgeless_mode}, 8'h01);
    cm(8'h08);
    meas(8'h00, 8'h01);
    mod_value = 10'h001;
    wr(16'hfe0d, 8'h0b);
    cm(8'h00);
    meas(8'h02, 8'h05);
    wr(16'hfe0d, 8'h0a);
    cm(8'h00);
    meas(8'h04, 8'h05);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
